/* etg_harness.sv */
// Traffic harness: packet generator, packet monitor and user I/O staging.
// Assumes the core end on the link; the clock doubles as the init clock.
// Notes on behaviour
// - Generator sends only after lock and alignment.
// - Monitor waits for lock, alignment, then checks.
// - Any compare mismatch raises data failure.
// - Continuous input streams forever, else fixed burst.
// - Operator drops continuous before lane switch.
// - Switch request writes reconfig, then reruns check.
// - Switch request one pulse until realigned.
// - Restart acts only when both busy are low.
// - Generator and monitor each drive busy.
// - Lane mode low ten-lane, high four-lane.
// - Statistics match high when counts agree.
// - Simplex transmit waits for simplex receiver aligned.
// - Done indicators after all packets sent/received.
// - Separate lock and alignment indicators.
// - All user I/O pass three registers.
// - Init clock drives reset and reconfig logic.
// - Operator tick triggers statistics snapshot.
`timescale 1ns/100ps
module etg_harness #(
	parameter bit SWITCHABLE = 1'b1,
	parameter bit SIMPLEX_TX = 1'b0
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	etg_link_if.harness link,
	input wire logic cont_traffic_in,
	input wire logic lane_switch_req_in,
	input wire logic restart_req_in,
	input wire logic simplex_rx_aligned_in,
	input wire logic perf_snapshot_tick_in,
	output logic transmit_serdes_lock_ind_out,
	output logic receive_serdes_lock_ind_out,
	output logic rx_aligned_ind_out,
	output logic tx_done_out,
	output logic rx_done_out,
	output logic data_fail_out,
	output logic tx_busy_out,
	output logic rx_busy_out,
	output logic lane_mode_out,
	output logic stat_match_out
);
	import etg_pkg::*;

	logic [ETG_SYNC_STAGES-1:0][ETG_NUM_IN-1:0] in_q, in_d;
	logic [ETG_SYNC_STAGES-1:0][ETG_NUM_OUT-1:0] out_q, out_d;
	etg_gen_state_t gen_q, gen_d;
	etg_mon_state_t mon_q, mon_d;
	logic [15:0] tpkt_q, tpkt_d, tword_q, tword_d, rpkt_q, rpkt_d, rword_q, rword_d;
	logic [ETG_DW-1:0] tdata_q, tdata_d;
	logic tlast_q, tlast_d, tdone_q, tdone_d, rdone_q, rdone_d, fail_q, fail_d;
	logic pend_q, pend_d, lane_q, lane_d, match_q, match_d;
	logic [3:0] ridx_q, ridx_d;
	logic link_up, restart_go, mon_clear, cont_s, tx_busy, rx_busy;

	// ***************************************************
	// User input staging
	// ***************************************************
	always_comb begin
		in_d = {in_q[1:0], perf_snapshot_tick_in, simplex_rx_aligned_in, restart_req_in,
			lane_switch_req_in, cont_traffic_in};
	end

	assign cont_s = in_q[2][ETG_IN_CONT];
	assign link_up = link.serdes_tx_locked && link.serdes_rx_locked && link.rx_aligned;
	assign tx_busy = (gen_q != ETG_GEN_DONE);
	assign rx_busy = (mon_q != ETG_MON_DONE);
	assign restart_go = in_q[2][ETG_IN_RESTART] && !tx_busy && !rx_busy;
	assign link.perf_tick = in_q[2][ETG_IN_TICK];

	// ***************************************************
	// Packet generator
	// ***************************************************
	assign link.tx_valid = (gen_q == ETG_GEN_SEND);
	assign link.tx_data = tdata_q;
	assign link.tx_last = tlast_q;
	assign link.rcfg_wr = (gen_q == ETG_GEN_RCFG);
	assign link.rcfg_addr = 10'(ETG_RCFG_BASE + {6'h00, ridx_q});
	assign link.rcfg_data = lane_q ? ETG_RCFG_TEN_LANE : ETG_RCFG_FOUR_LANE;

	always_comb begin
		gen_d = gen_q;
		tpkt_d = tpkt_q;
		tword_d = tword_q;
		tdone_d = tdone_q;
		lane_d = lane_q;
		ridx_d = ridx_q;
		mon_clear = 1'b0;
		pend_d = pend_q || (SWITCHABLE && in_q[2][ETG_IN_SWITCH]);
		case (gen_q)
			ETG_GEN_WAIT: begin
				if (pend_q) begin
					gen_d = ETG_GEN_RCFG;
				end else if (link_up && (!SIMPLEX_TX || in_q[2][ETG_IN_SIMPLEX])) begin
					gen_d = ETG_GEN_SEND;
				end
			end
			ETG_GEN_SEND: begin
				if (!link_up) begin
					gen_d = ETG_GEN_WAIT;
				end else if (link.tx_ready) begin
					tword_d = tword_q + 16'h0001;
					if (tlast_q) begin
						tword_d = 16'h0000;
						tpkt_d = tpkt_q + 16'h0001;
						if (!cont_s && (tpkt_d == ETG_BURST_PKTS)) begin
							gen_d = ETG_GEN_DONE;
							tdone_d = 1'b1;
						end else if (pend_q) begin
							gen_d = ETG_GEN_RCFG;
						end
					end
				end
			end
			ETG_GEN_DONE: begin
				if (restart_go) begin
					gen_d = ETG_GEN_WAIT;
					tpkt_d = 16'h0000;
					tword_d = 16'h0000;
					tdone_d = 1'b0;
					mon_clear = 1'b1;
				end else if (pend_q) begin
					gen_d = ETG_GEN_RCFG;
				end
			end
			ETG_GEN_RCFG: begin
				if (link.rcfg_ack) begin
					ridx_d = ridx_q + 4'h1;
					if (ridx_q == ETG_RCFG_LAST) begin
						ridx_d = 4'h0;
						lane_d = ~lane_q;
						gen_d = ETG_GEN_WAIT;
						tpkt_d = 16'h0000;
						tword_d = 16'h0000;
						tdone_d = 1'b0;
						mon_clear = 1'b1;
						pend_d = SWITCHABLE && in_q[2][ETG_IN_SWITCH];
					end
				end
			end
			default: begin
				gen_d = ETG_GEN_WAIT;
			end
		endcase
		tdata_d = etg_pattern(tpkt_d, tword_d);
		tlast_d = (tword_d == ETG_LAST_WORD);
	end

	// ***************************************************
	// Packet monitor
	// ***************************************************
	assign link.rx_ready = (mon_q == ETG_MON_RECV);

	always_comb begin
		mon_d = mon_q;
		rpkt_d = rpkt_q;
		rword_d = rword_q;
		rdone_d = rdone_q;
		fail_d = fail_q;
		case (mon_q)
			ETG_MON_WAIT: begin
				if (link_up) begin
					mon_d = ETG_MON_RECV;
				end
			end
			ETG_MON_RECV: begin
				if (!link_up) begin
					mon_d = ETG_MON_WAIT;
				end else if (link.rx_valid) begin
					if ((link.rx_data != etg_pattern(rpkt_q, rword_q)) ||
						(link.rx_last != (rword_q == ETG_LAST_WORD))) begin
						fail_d = 1'b1;
					end
					rword_d = rword_q + 16'h0001;
					if (link.rx_last) begin
						rword_d = 16'h0000;
						rpkt_d = rpkt_q + 16'h0001;
						if (!cont_s && (rpkt_d == ETG_BURST_PKTS)) begin
							mon_d = ETG_MON_DONE;
							rdone_d = 1'b1;
						end
					end
				end
			end
			ETG_MON_DONE: begin
				mon_d = ETG_MON_DONE;
			end
			default: begin
				mon_d = ETG_MON_WAIT;
			end
		endcase
		if (mon_clear) begin
			mon_d = ETG_MON_WAIT;
			rpkt_d = 16'h0000;
			rword_d = 16'h0000;
			rdone_d = 1'b0;
			fail_d = 1'b0;
		end
		match_d = (link.stat_tx_pkts == link.stat_rx_pkts);
	end

	// ***************************************************
	// User output staging
	// ***************************************************
	always_comb begin
		out_d = {out_q[1:0], match_q, lane_q && SWITCHABLE, rx_busy, tx_busy, fail_q,
			rdone_q, tdone_q, link.rx_aligned, link.serdes_rx_locked, link.serdes_tx_locked};
	end

	assign transmit_serdes_lock_ind_out = out_q[2][0];
	assign receive_serdes_lock_ind_out = out_q[2][1];
	assign rx_aligned_ind_out = out_q[2][2];
	assign tx_done_out = out_q[2][3];
	assign rx_done_out = out_q[2][4];
	assign data_fail_out = out_q[2][5];
	assign tx_busy_out = out_q[2][6];
	assign rx_busy_out = out_q[2][7];
	assign lane_mode_out = out_q[2][8];
	assign stat_match_out = out_q[2][9];

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			in_q <= '0;
			out_q <= '0;
			gen_q <= ETG_GEN_WAIT;
			mon_q <= ETG_MON_WAIT;
			tpkt_q <= 16'h0000;
			tword_q <= 16'h0000;
			rpkt_q <= 16'h0000;
			rword_q <= 16'h0000;
			tdata_q <= '0;
			tlast_q <= 1'b0;
			tdone_q <= 1'b0;
			rdone_q <= 1'b0;
			fail_q <= 1'b0;
			pend_q <= 1'b0;
			lane_q <= 1'b0;
			match_q <= 1'b0;
			ridx_q <= 4'h0;
		end else begin
			in_q <= in_d;
			out_q <= out_d;
			gen_q <= gen_d;
			mon_q <= mon_d;
			tpkt_q <= tpkt_d;
			tword_q <= tword_d;
			rpkt_q <= rpkt_d;
			rword_q <= rword_d;
			tdata_q <= tdata_d;
			tlast_q <= tlast_d;
			tdone_q <= tdone_d;
			rdone_q <= rdone_d;
			fail_q <= fail_d;
			pend_q <= pend_d;
			lane_q <= lane_d;
			match_q <= match_d;
			ridx_q <= ridx_d;
		end
	end

endmodule : etg_harness

/* etg_pkg.sv */
// Shared constants, states and the test pattern for the traffic harness.
// Assumes one clock for harness and core end; build options are parameters.
package etg_pkg;

	// ***************************************************
	// Widths and counts
	// ***************************************************
	localparam int ETG_DW = 64;
	localparam int ETG_SYNC_STAGES = 3;
	localparam logic [15:0] ETG_PKT_WORDS = 16'h0008;
	localparam logic [15:0] ETG_LAST_WORD = 16'h0007;
	localparam logic [15:0] ETG_BURST_PKTS = 16'h0020;
	localparam logic [15:0] ETG_PAT_TAG = 16'hC0DE;
	localparam logic [7:0] ETG_REALIGN_CYC = 8'h20;

	// ***************************************************
	// User input bit positions and output count
	// ***************************************************
	localparam int ETG_NUM_IN = 5;
	localparam int ETG_IN_CONT = 0;
	localparam int ETG_IN_SWITCH = 1;
	localparam int ETG_IN_RESTART = 2;
	localparam int ETG_IN_SIMPLEX = 3;
	localparam int ETG_IN_TICK = 4;
	localparam int ETG_NUM_OUT = 10;

	// ***************************************************
	// Reconfiguration writes
	// ***************************************************
	localparam logic [9:0] ETG_RCFG_BASE = 10'h010;
	localparam logic [3:0] ETG_RCFG_WRITES = 4'h4;
	localparam logic [3:0] ETG_RCFG_LAST = 4'h3;
	localparam logic [15:0] ETG_RCFG_TEN_LANE = 16'h0000;
	localparam logic [15:0] ETG_RCFG_FOUR_LANE = 16'h0001;

	// ***************************************************
	// States
	// ***************************************************
	typedef enum logic [1:0] {
		ETG_GEN_WAIT = 2'b00,
		ETG_GEN_SEND = 2'b01,
		ETG_GEN_DONE = 2'b10,
		ETG_GEN_RCFG = 2'b11
	} etg_gen_state_t;

	typedef enum logic [1:0] {
		ETG_MON_WAIT = 2'b00,
		ETG_MON_RECV = 2'b01,
		ETG_MON_DONE = 2'b10
	} etg_mon_state_t;

	// Word of a frame: tag, packet number, word number, inverted packet number.
	function automatic logic [ETG_DW-1:0] etg_pattern(input logic [15:0] pkt,
		input logic [15:0] word);
		etg_pattern = {ETG_PAT_TAG, pkt, word, ~pkt};
	endfunction : etg_pattern

endpackage : etg_pkg

/* etg_link_if.sv */
// Link between the traffic harness and the MAC/transceiver core end.
// Assumes both ends run on the same clock and synchronous reset.
`timescale 1ns/100ps
interface etg_link_if (
	input wire logic clk,
	input wire logic rst
);
	import etg_pkg::*;

	logic serdes_tx_locked;
	logic serdes_rx_locked;
	logic rx_aligned;
	logic tx_valid;
	logic tx_ready;
	logic tx_last;
	logic [ETG_DW-1:0] tx_data;
	logic rx_valid;
	logic rx_ready;
	logic rx_last;
	logic [ETG_DW-1:0] rx_data;
	logic rcfg_wr;
	logic [9:0] rcfg_addr;
	logic [15:0] rcfg_data;
	logic rcfg_ack;
	logic perf_tick;
	logic [15:0] stat_tx_pkts;
	logic [15:0] stat_rx_pkts;

	modport harness (
		input serdes_tx_locked, serdes_rx_locked, rx_aligned,
		output tx_valid, tx_last, tx_data, input tx_ready,
		input rx_valid, rx_last, rx_data, output rx_ready,
		output rcfg_wr, rcfg_addr, rcfg_data, input rcfg_ack,
		output perf_tick, input stat_tx_pkts, stat_rx_pkts
	);

	modport core (
		output serdes_tx_locked, serdes_rx_locked, rx_aligned,
		input tx_valid, tx_last, tx_data, output tx_ready,
		output rx_valid, rx_last, rx_data, input rx_ready,
		input rcfg_wr, rcfg_addr, rcfg_data, output rcfg_ack,
		input perf_tick, output stat_tx_pkts, stat_rx_pkts
	);

endinterface : etg_link_if

/* etg_core_end.sv */
// Core end: loopback MAC/transceiver stand-in plus the operator request gate.
// Assumes lock and alignment pins are synchronous; link joined by the testbench.
`timescale 1ns/100ps
module etg_core_end (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	etg_link_if.core link,
	input wire logic tx_lock_in,
	input wire logic rx_lock_in,
	input wire logic align_in,
	input wire logic op_cont_in,
	input wire logic op_switch_in,
	input wire logic op_restart_in,
	input wire logic tx_busy_in,
	input wire logic rx_busy_in,
	output logic cont_traffic_out,
	output logic lane_switch_out,
	output logic restart_out
);
	import etg_pkg::*;

	logic [ETG_DW:0] buf_q [2];
	logic [ETG_DW:0] buf_d [2];
	logic wptr_q, wptr_d, rptr_q, rptr_d;
	logic [1:0] cnt_q, cnt_d;
	logic [7:0] realign_q, realign_d;
	logic ack_q, ack_d;
	logic [15:0] txc_q, txc_d, rxc_q, rxc_d, stx_q, stx_d, srx_q, srx_d;
	logic sw_prev_q, sw_prev_d, arm_q, arm_d, pulse_q, pulse_d;
	logic block_q, block_d, drop_q, drop_d;
	logic cont_q, cont_d, restart_q, restart_d;
	logic aligned_w, wr_w, rd_w;

	// ***************************************************
	// Status, two-entry buffer and statistics
	// ***************************************************
	assign aligned_w = align_in && rx_lock_in && (realign_q == 8'h00);
	assign link.serdes_tx_locked = tx_lock_in;
	assign link.serdes_rx_locked = rx_lock_in;
	assign link.rx_aligned = aligned_w;
	assign link.tx_ready = (cnt_q != 2'h2);
	assign link.rx_valid = (cnt_q != 2'h0);
	assign link.rx_data = buf_q[rptr_q][ETG_DW-1:0];
	assign link.rx_last = buf_q[rptr_q][ETG_DW];
	assign link.rcfg_ack = ack_q;
	assign link.stat_tx_pkts = stx_q;
	assign link.stat_rx_pkts = srx_q;
	assign wr_w = link.tx_valid && (cnt_q != 2'h2);
	assign rd_w = link.rx_ready && (cnt_q != 2'h0);

	always_comb begin
		buf_d = buf_q;
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		cnt_d = cnt_q;
		txc_d = txc_q;
		rxc_d = rxc_q;
		stx_d = stx_q;
		srx_d = srx_q;
		if (wr_w) begin
			buf_d[wptr_q] = {link.tx_last, link.tx_data};
			wptr_d = ~wptr_q;
			if (link.tx_last) begin
				txc_d = txc_q + 16'h0001;
			end
		end
		if (rd_w) begin
			rptr_d = ~rptr_q;
			if (link.rx_last) begin
				rxc_d = rxc_q + 16'h0001;
			end
		end
		cnt_d = 2'(cnt_q + {1'b0, wr_w} - {1'b0, rd_w});
		if (link.perf_tick) begin
			stx_d = txc_q;
			srx_d = rxc_q;
		end
		ack_d = link.rcfg_wr && !ack_q;
		realign_d = (realign_q != 8'h00) ? realign_q - 8'h01 : 8'h00;
		if (link.rcfg_wr && !ack_q) begin
			realign_d = ETG_REALIGN_CYC;
		end
	end

	// ***************************************************
	// Operator request gate
	// ***************************************************
	always_comb begin
		sw_prev_d = op_switch_in;
		arm_d = arm_q;
		pulse_d = 1'b0;
		block_d = block_q;
		drop_d = drop_q;
		if (op_switch_in && !sw_prev_q && !block_q && !arm_q) begin
			arm_d = 1'b1;
		end
		if (arm_q) begin
			arm_d = 1'b0;
			pulse_d = 1'b1;
			block_d = 1'b1;
			drop_d = 1'b0;
		end else if (block_q) begin
			if (!aligned_w) begin
				drop_d = 1'b1;
			end else if (drop_q) begin
				block_d = 1'b0;
			end
		end
		cont_d = op_cont_in && !arm_d && !block_d;
		restart_d = op_restart_in && !tx_busy_in && !rx_busy_in;
	end

	assign cont_traffic_out = cont_q;
	assign lane_switch_out = pulse_q;
	assign restart_out = restart_q;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			wptr_q <= 1'b0;
			rptr_q <= 1'b0;
			cnt_q <= 2'h0;
			txc_q <= 16'h0000;
			rxc_q <= 16'h0000;
			stx_q <= 16'h0000;
			srx_q <= 16'h0000;
			ack_q <= 1'b0;
			realign_q <= 8'h00;
			sw_prev_q <= 1'b0;
			arm_q <= 1'b0;
			pulse_q <= 1'b0;
			block_q <= 1'b0;
			drop_q <= 1'b0;
			cont_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			buf_q <= buf_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q <= cnt_d;
			txc_q <= txc_d;
			rxc_q <= rxc_d;
			stx_q <= stx_d;
			srx_q <= srx_d;
			ack_q <= ack_d;
			realign_q <= realign_d;
			sw_prev_q <= sw_prev_d;
			arm_q <= arm_d;
			pulse_q <= pulse_d;
			block_q <= block_d;
			drop_q <= drop_d;
			cont_q <= cont_d;
			restart_q <= restart_d;
		end
	end

endmodule : etg_core_end

/* etg_link_checker.sv */
// Concurrent checks on the link between the traffic harness and the core end.
// Assumes one clock, a synchronous active-high reset, and link signals as inputs.
`timescale 1ns/100ps
module etg_link_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic rx_aligned,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_last,
	input wire logic [etg_pkg::ETG_DW-1:0] tx_data,
	input wire logic rx_ready,
	input wire logic rcfg_wr,
	input wire logic [9:0] rcfg_addr,
	input wire logic [15:0] rcfg_data,
	input wire logic rcfg_ack
);
	import etg_pkg::*;

	// ****************************************
	// Link properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_TX_HOLD_OFF: assert property (!rx_aligned [*8] |-> !tx_valid)
		else $error("Frame word offered while alignment is down");
	AST_MON_HOLD_OFF: assert property (!rx_aligned [*8] |-> !rx_ready)
		else $error("Monitor accepting while alignment is down");
	AST_TX_STALL_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("Stalled frame word changed or withdrawn");
	AST_TX_PATTERN: assert property (tx_valid |->
		tx_data[63:48] == ETG_PAT_TAG && tx_data[15:0] == ~tx_data[47:32])
		else $error("Frame word does not carry the test pattern");
	AST_TX_LAST_WORD: assert property (tx_valid |->
		tx_last == (tx_data[31:16] == ETG_LAST_WORD))
		else $error("End-of-frame flag on the wrong word");
	AST_RCFG_RANGE: assert property (rcfg_wr |-> rcfg_addr >= ETG_RCFG_BASE &&
		rcfg_addr <= ETG_RCFG_BASE + 10'(ETG_RCFG_LAST) &&
		(rcfg_data == ETG_RCFG_TEN_LANE || rcfg_data == ETG_RCFG_FOUR_LANE))
		else $error("Reconfiguration write outside its address or data set");
	AST_RCFG_HOLD: assert property (rcfg_wr && !rcfg_ack |=>
		rcfg_wr && $stable(rcfg_addr) && $stable(rcfg_data))
		else $error("Reconfiguration write changed before acknowledge");
	AST_RCFG_STEP: assert property (rcfg_wr && rcfg_ack &&
		rcfg_addr != ETG_RCFG_BASE + 10'(ETG_RCFG_LAST) |=>
		rcfg_wr && rcfg_addr == $past(rcfg_addr) + 10'h001 && $stable(rcfg_data))
		else $error("Reconfiguration writes not back to back in address order");

	COV_FRAME_END: cover property (tx_valid && tx_ready && tx_last);
	COV_RCFG_DONE: cover property (rcfg_wr && rcfg_ack);
	COV_TX_STALL: cover property (tx_valid && !tx_ready);

endmodule : etg_link_checker

/* ethernet_traffic_gen_monitor_tb.sv */
// Self-checking bench: harness and core end joined over the link interface.
// Assumes the package, interface, both design ends and the link checker compiled first.
`timescale 1ns/100ps
module ethernet_traffic_gen_monitor_tb;
	import etg_pkg::*;

	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic tx_lock = 1'b0, rx_lock = 1'b0, align = 1'b0, tick = 1'b0;
	logic op_cont = 1'b0, op_switch = 1'b0, op_restart = 1'b0;
	logic cont, lswitch, restart, tx_lock_ind, rx_lock_ind, align_ind;
	logic tx_done, rx_done, fail, tx_busy, rx_busy, lane, smatch;
	int err_total = 0;
	int checks_done = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	// ****************************************
	// Design under test
	// ****************************************
	etg_link_if link (.clk(sys_clk_in), .rst(rst_in));

	etg_harness #(.SWITCHABLE(1'b1), .SIMPLEX_TX(1'b0)) u_etg_harness (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link.harness),
		.cont_traffic_in(cont), .lane_switch_req_in(lswitch), .restart_req_in(restart),
		.simplex_rx_aligned_in(1'b1), .perf_snapshot_tick_in(tick),
		.transmit_serdes_lock_ind_out(tx_lock_ind), .receive_serdes_lock_ind_out(rx_lock_ind),
		.rx_aligned_ind_out(align_ind), .tx_done_out(tx_done), .rx_done_out(rx_done),
		.data_fail_out(fail), .tx_busy_out(tx_busy), .rx_busy_out(rx_busy),
		.lane_mode_out(lane), .stat_match_out(smatch)
	);

	etg_core_end u_etg_core_end (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link.core),
		.tx_lock_in(tx_lock), .rx_lock_in(rx_lock), .align_in(align),
		.op_cont_in(op_cont), .op_switch_in(op_switch), .op_restart_in(op_restart),
		.tx_busy_in(tx_busy), .rx_busy_in(rx_busy), .cont_traffic_out(cont),
		.lane_switch_out(lswitch), .restart_out(restart)
	);

	etg_link_checker u_etg_link_checker (
		.clk(sys_clk_in), .rst(rst_in), .rx_aligned(link.rx_aligned),
		.tx_valid(link.tx_valid), .tx_ready(link.tx_ready), .tx_last(link.tx_last),
		.tx_data(link.tx_data), .rx_ready(link.rx_ready), .rcfg_wr(link.rcfg_wr),
		.rcfg_addr(link.rcfg_addr), .rcfg_data(link.rcfg_data), .rcfg_ack(link.rcfg_ack)
	);

	// ****************************************
	// Helpers and scenarios
	// ****************************************
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : cyc

	function automatic logic sel(input int k);
		case (k)
			0: sel = tx_done & rx_done;
			1: sel = lane;
			default: sel = tx_busy & rx_busy;
		endcase
	endfunction : sel

	// Bounded wait; running out of cycles ends the run as a failure.
	task automatic wait_for(input int k, input logic v, input int lim);
		int n = 0;
		while (sel(k) !== v && n < lim) begin
			@(negedge sys_clk_in);
			n++;
		end
		if (sel(k) !== v) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, sel(k), v);
			final_report();
		end
	endtask : wait_for

	task automatic t_link_up();
		tx_lock = 1'b1;
		cyc(10);
		chk(tx_lock_ind, 1'b1);
		chk(rx_lock_ind, 1'b0);
		chk(tx_busy & rx_busy, 1'b1);
		rx_lock = 1'b1;
		cyc(40);
		chk(rx_lock_ind, 1'b1);
		chk(align_ind, 1'b0);
		chk(link.tx_valid, 1'b0);
		chk(link.rx_ready, 1'b0);
		chk(tx_done | rx_done, 1'b0);
		align = 1'b1;
		cyc(10);
		chk(align_ind, 1'b1);
	endtask : t_link_up

	task automatic t_burst();
		wait_for(0, 1'b1, 3000);
		chk(fail, 1'b0);
		chk(tx_busy | rx_busy, 1'b0);
		tick = 1'b1;
		cyc(1);
		tick = 1'b0;
		cyc(12);
		chk(smatch, 1'b1);
		chk(link.stat_tx_pkts, ETG_BURST_PKTS);
		chk(link.stat_rx_pkts, ETG_BURST_PKTS);
	endtask : t_burst

	task automatic t_restart(input logic c);
		op_cont = c;
		op_restart = 1'b1;
		wait_for(2, 1'b1, 40);
		op_restart = 1'b0;
		cyc(2);
		chk(tx_done | rx_done, 1'b0);
		chk(fail, 1'b0);
		if (c) begin
			cyc(1000);
			chk(tx_done, 1'b0);
			chk(tx_busy, 1'b1);
		end else begin
			wait_for(0, 1'b1, 3000);
			chk(fail, 1'b0);
		end
	endtask : t_restart

	// Continuous traffic is dropped first, then the switch is a single pulse.
	task automatic t_switch(input logic m);
		op_cont = 1'b0;
		cyc(10);
		op_switch = 1'b1;
		cyc(1);
		op_switch = 1'b0;
		wait_for(1, m, 3000);
		// A second request before realignment must be swallowed by the gate.
		op_switch = 1'b1;
		cyc(1);
		op_switch = 1'b0;
		cyc(8);
		chk(link.rcfg_wr, 1'b0);
		chk(lane, m);
		chk(tx_done | rx_done, 1'b0);
		wait_for(0, 1'b1, 4000);
		chk(fail, 1'b0);
		chk(lane, m);
	endtask : t_switch

	initial begin
		cyc(2);
		rst_in = 1'b0;
		cyc(1);
		chk({tx_done, rx_done, fail, lane, smatch}, 5'h00);
		t_link_up();
		t_burst();
		t_restart(1'b1);
		t_switch(1'b1);
		t_switch(1'b0);
		t_restart(1'b0);
		final_report();
	end

endmodule : ethernet_traffic_gen_monitor_tb
